// >>> auto_msg_pkg.sv
`default_nettype none
package auto_msg_pkg;
  // ----------------------------------------------------------------------
  // matrix geometry
  // ----------------------------------------------------------------------
  localparam int CODE_W     = 7;
  localparam int ROWS       = 21;
  localparam int ROW_W      = 5;
  localparam int SHORT_LEN  = 3;
  localparam int IDENT_MAX  = 15;
  localparam int END_W      = 4;
  localparam logic [ROW_W-1:0] CALL_FIRST   = 5'h00;
  localparam logic [ROW_W-1:0] SECOND_FIRST = 5'h03;
  localparam logic [ROW_W-1:0] IDENT_FIRST  = 5'h06;
  localparam logic [ROW_W-1:0] SHORT_LAST   = 5'h02;
  localparam logic [CODE_W-1:0] CODE_RESET  = 7'h00;
  localparam logic [ROW_W-1:0]  ROW_RESET   = 5'h00;
  localparam logic [END_W-1:0]  END_RESET   = 4'h0;

  typedef enum logic [1:0] {KEY_CALL, KEY_SECOND, KEY_IDENT} key_t;
  typedef enum logic [1:0] {S_IDLE, S_SEND, S_WAIT} seq_state_t;

  typedef struct packed {
    logic              valid;
    logic [CODE_W-1:0] code;
  } char_t;

  typedef struct packed {
    seq_state_t        state;
    key_t              key;
    logic [ROW_W-1:0]  idx;
    char_t             out;
  } seq_t;
endpackage
`default_nettype wire

// >>> code_matrix.sv
`default_nettype none
module code_matrix
  #(parameter logic [auto_msg_pkg::ROWS*auto_msg_pkg::CODE_W-1:0]
      CONTENTS = '0)
  (
  // row select and data
  input  wire logic [auto_msg_pkg::ROW_W-1:0]  rowSel,
  output logic      [auto_msg_pkg::CODE_W-1:0] codeBitLines
  );
  logic [auto_msg_pkg::CODE_W-1:0] rows [auto_msg_pkg::ROWS];
  genvar g;
  generate
    for (g = 0; g < auto_msg_pkg::ROWS; g++)
    begin : gRow
      // a fitted element is a one; an empty place reads zero
      assign rows[g] = CONTENTS[g*auto_msg_pkg::CODE_W +: auto_msg_pkg::CODE_W];
    end
  endgenerate
  always_comb
  begin
    codeBitLines = '0;
    if (rowSel < 5'(auto_msg_pkg::ROWS))
    begin
      codeBitLines = rows[rowSel];
    end
  end
endmodule
`default_nettype wire

// >>> auto_message_sequencer.sv
`default_nettype none
module auto_message_sequencer
  #(parameter logic [auto_msg_pkg::ROWS*auto_msg_pkg::CODE_W-1:0]
      CONTENTS = '0)
  (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  // message keys from the keyboard pins
  input  wire logic                              callMessageKey,
  input  wire logic                              secondMessageKey,
  input  wire logic                              identifierMessageKey,
  // strap: identifier end position, 1..15 (0 acts as 1)
  input  wire logic [auto_msg_pkg::END_W-1:0]    identEndStrap,
  // character to the code converter
  output logic                                   charValid,
  output logic      [auto_msg_pkg::CODE_W-1:0]   charCode,
  input  wire logic                              charReady,
  output logic                                   busy
  );
  // --------------------------------------------------------------------
  // pin synchronisers and strap capture
  // --------------------------------------------------------------------
  logic [2:0] keyMeta_q;
  logic [2:0] keySync_q;
  logic [auto_msg_pkg::END_W-1:0] strapMeta_q;
  logic [auto_msg_pkg::END_W-1:0] strapSync_q;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      keyMeta_q   <= 3'h0;
      keySync_q   <= 3'h0;
      strapMeta_q <= auto_msg_pkg::END_RESET;
      strapSync_q <= auto_msg_pkg::END_RESET;
    end
    else
    begin
      keyMeta_q   <= {identifierMessageKey, secondMessageKey, callMessageKey};
      keySync_q   <= keyMeta_q;
      strapMeta_q <= identEndStrap;
      strapSync_q <= strapMeta_q;
    end
  end

  // --------------------------------------------------------------------
  // sequencer
  // --------------------------------------------------------------------
  auto_msg_pkg::seq_t s_q;
  auto_msg_pkg::seq_t s_d;
  logic [auto_msg_pkg::ROW_W-1:0]  rowSel;
  logic [auto_msg_pkg::CODE_W-1:0] rowCode;
  logic [auto_msg_pkg::ROW_W-1:0]  lastIdx;
  logic                            keyHeld;
  logic                            anyKey;

  code_matrix #(.CONTENTS(CONTENTS)) uMatrix
  (
    .rowSel       (rowSel),
    .codeBitLines (rowCode)
  );

  assign anyKey = |keySync_q;
  // strap value n ends the identifier after n programmed rows; 0 ends it after one row
  always_comb
  begin
    lastIdx = auto_msg_pkg::SHORT_LAST;
    keyHeld = 1'b0;
    unique case (s_q.key)
      auto_msg_pkg::KEY_CALL:   keyHeld = keySync_q[0];
      auto_msg_pkg::KEY_SECOND: keyHeld = keySync_q[1];
      default:
      begin
        keyHeld = keySync_q[2];
        lastIdx = 5'(strapSync_q) - 5'h01;
        if (strapSync_q == 4'h0)
        begin
          lastIdx = 5'h00;
        end
      end
    endcase
    unique case (s_q.key)
      auto_msg_pkg::KEY_CALL:   rowSel = auto_msg_pkg::CALL_FIRST + s_q.idx;
      auto_msg_pkg::KEY_SECOND: rowSel = auto_msg_pkg::SECOND_FIRST + s_q.idx;
      default:                  rowSel = auto_msg_pkg::IDENT_FIRST + s_q.idx;
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    unique case (s_q.state)
      auto_msg_pkg::S_IDLE:
      begin
        if (anyKey)
        begin
          // lowest key wins if several are pressed together
          s_d.key   = keySync_q[0] ? auto_msg_pkg::KEY_CALL
                    : keySync_q[1] ? auto_msg_pkg::KEY_SECOND
                    : auto_msg_pkg::KEY_IDENT;
          s_d.idx   = auto_msg_pkg::ROW_RESET;
          s_d.state = auto_msg_pkg::S_SEND;
        end
      end
      auto_msg_pkg::S_SEND:
      begin
        s_d.out.valid = 1'b1;
        // code goes on unchanged; the converter applies the mode
        s_d.out.code  = rowCode;
        s_d.state     = auto_msg_pkg::S_WAIT;
      end
      auto_msg_pkg::S_WAIT:
      begin
        if (charReady)
        begin
          s_d.out.valid = 1'b0;
          s_d.state     = auto_msg_pkg::S_SEND;
          if (s_q.idx >= lastIdx)
          begin
            s_d.idx = auto_msg_pkg::ROW_RESET;
            if (!keyHeld)
            begin
              s_d.state = auto_msg_pkg::S_IDLE;
            end
          end
          else
          begin
            s_d.idx = s_q.idx + 5'h01;
          end
        end
      end
      default: s_d.state = auto_msg_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s_q.state     <= auto_msg_pkg::S_IDLE;
      s_q.key       <= auto_msg_pkg::KEY_CALL;
      s_q.idx       <= auto_msg_pkg::ROW_RESET;
      s_q.out.valid <= 1'b0;
      s_q.out.code  <= auto_msg_pkg::CODE_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign charValid = s_q.out.valid;
  assign charCode  = s_q.out.code;
  assign busy      = s_q.state != auto_msg_pkg::S_IDLE;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  a_valid_holds: assert property (@(posedge clk) disable iff (!rst_n)
    charValid && !charReady |=> charValid && $stable(charCode))
    else $error("character dropped before taken");
  a_press_starts: assert property (@(posedge clk) disable iff (!rst_n)
    !busy && anyKey |=> ##1 charValid)
    else $error("key press did not start a sequence");
  a_short_wraps: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.key != auto_msg_pkg::KEY_IDENT |-> s_q.idx <= 5'h02)
    else $error("short message exceeded three characters");
  a_ident_bound: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.idx < 5'h0f)
    else $error("identifier index beyond fifteen");
  a_repeat_first: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.state == auto_msg_pkg::S_WAIT && charReady && s_q.idx >= lastIdx
    && keyHeld |=> s_q.idx == 5'h00 && busy)
    else $error("held key did not restart sequence");
  a_code_pass: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.state == auto_msg_pkg::S_SEND |=> charCode == $past(rowCode))
    else $error("code altered on the way out");
  a_rows_group: assert property (@(posedge clk) disable iff (!rst_n)
    busy && s_q.key == auto_msg_pkg::KEY_SECOND |-> rowSel inside {[3:5]})
    else $error("second key reading wrong rows");
  a_end_stops: assert property (@(posedge clk) disable iff (!rst_n)
    s_q.state == auto_msg_pkg::S_WAIT && charReady && s_q.idx >= lastIdx
    && !keyHeld |=> !busy && !charValid)
    else $error("sequence ran past its end");
endmodule
`default_nettype wire

// >>> char_sink.sv
`default_nettype none
module char_sink
  (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // character handshake
  input  wire logic charValid,
  input  wire logic slow,
  output var  logic charReady
  );
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] lfsr;

  // stalls come from a small lfsr so the gaps vary from char to char
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      lfsr      <= 8'h5a;
      charReady <= 1'b0;
    end
    else
    begin
      lfsr      <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      charReady <= !slow || lfsr[0];
    end
  end
endmodule
`default_nettype wire

// >>> auto_message_sequencer_test.sv
`default_nettype none
module auto_message_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int W = auto_msg_pkg::ROWS * auto_msg_pkg::CODE_W;
  logic        clk;
  logic        rst_n;
  logic [2:0]  keys;
  logic [3:0]  strap;
  logic        slow;
  logic        charValid;
  logic [6:0]  charCode;
  logic        charReady;
  logic        busy;
  logic [31:0] seed;
  int          fails;
  int          compares;
  logic [6:0]  got[$];

  // all-ones and all-zero rows exercise every bit line both ways
  function automatic logic [6:0] rowCode(input int r);
    if (r == 0) return 7'h7f;
    if (r == 1) return 7'h00;
    return 7'(r * 5 + 33);
  endfunction

  function automatic logic [W-1:0] fill();
    for (int r = 0; r < auto_msg_pkg::ROWS; r++) fill[r*7+:7] = rowCode(r);
  endfunction

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  auto_message_sequencer #(.CONTENTS(fill())) DUT (
    .clk(clk), .rst_n(rst_n), .callMessageKey(keys[2]),
    .secondMessageKey(keys[1]), .identifierMessageKey(keys[0]),
    .identEndStrap(strap), .charValid(charValid), .charCode(charCode),
    .charReady(charReady), .busy(busy));

  char_sink sink (.clk(clk), .rst_n(rst_n), .charValid(charValid),
    .slow(slow), .charReady(charReady));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
    if (rst_n && charValid === 1'b1 && charReady === 1'b1)
      got.push_back(charCode);

  task automatic check(input string name, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (fails == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // hold the key until want chars were taken, then let the pass finish
  task automatic runKey(input logic [2:0] mask, input int k, input int want);
    int len;
    int n;
    len = (k < 2) ? 3 : ((strap == 4'h0) ? 1 : int'(strap));
    got.delete();
    keys = mask;
    n = 0;
    while (got.size() < want && n < 3000) begin @(negedge clk); n++; end
    keys = 3'b000;
    while (busy !== 1'b0 && n < 4000) begin @(negedge clk); n++; end
    check("idle", {7'h00, busy}, 8'h00);
    check("taken", 8'(got.size() >= want), 8'h01);
    check("whole", 8'(got.size() % len), 8'h00);
    foreach (got[i])
      check("char", {1'b0, got[i]}, {1'b0, rowCode(k * 3 + i % len)});
  endtask

  initial
  begin
    int st[6];
    seed = 32'h0000_0054;
    fails = 0;
    compares = 0;
    keys = 3'b000;
    strap = 4'hf;
    slow = 1'b0;
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    runKey(3'b100, 0, 7);
    slow = 1'b1;
    runKey(3'b111, 0, 3);
    runKey(3'b010, 1, 4);
    st = '{0, 1, 15, 2, 7, 9};
    foreach (st[i])
    begin
      strap = 4'(st[i]);
      slow = xs() % 2;
      repeat (3) @(negedge clk);
      runKey(3'b001, 2, int'(xs() % 20) + 1);
    end
    repeat (6)
    begin
      int k;
      k = int'(xs() % 3);
      strap = 4'(xs());
      slow = xs() % 2;
      repeat (3) @(negedge clk);
      runKey(3'(1 << (2 - k)), k, int'(xs() % 16) + 1);
    end
    end_of_test();
  end

  initial
  begin
    #(50 * 60000);
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
